// >>> src/swld_ctrl.sv
// Single-wire dimming controller: pulse counting, shutdown timing, thermal cut-out.
// Assumes the host ties enable and both dimming inputs to one line (common_line).
`timescale 1ns/10ps
module swld_ctrl
  import swld_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYC = swld_pkg::SHUTDOWN_LOW_CYC,
  parameter int unsigned NP           = swld_pkg::PRIMARY_SINKS,
  parameter int unsigned NS           = swld_pkg::SECONDARY_SINKS
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          common_line,
  input  wire logic                          over_temp,
  input  wire logic                          temp_cooled,
  input  wire logic [NP-1:0]                 primary_sink_at_pump,
  input  wire logic [NS-1:0]                 secondary_sink_at_pump,
  output logic                               device_enabled,
  output logic                               thermal_shutdown,
  output logic [swld_pkg::CUR_W-1:0]         current_code,
  output logic [NP-1:0]                      primary_led_sinks,
  output logic [NS-1:0]                      secondary_led_sinks
);
  import swld_pkg::*;

  swld_sync_if line_s ();
  // Raw flags feed three-flop synchronisers so they may come from analog
  logic [2:0] ot_q;
  logic [2:0] ot_d;
  logic [2:0] cool_q;
  logic [2:0] cool_d;

  swld_line_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line_in  (common_line),
    .sync     (line_s)
  );

  swld_state_e          state_q;
  swld_state_e          state_d;
  logic [LOW_CNT_W-1:0] low_cnt_q;
  logic [LOW_CNT_W-1:0] low_cnt_d;
  logic [CUR_W-1:0]     cur_q;
  logic [CUR_W-1:0]     cur_d;
  logic                 therm_q;
  logic                 therm_d;
  logic                 ot_lvl_q;
  logic                 ot_lvl_d;
  logic                 cool_lvl_q;
  logic                 cool_lvl_d;
  logic [NP-1:0]        psink_q;
  logic [NP-1:0]        psink_d;
  logic [NS-1:0]        ssink_q;
  logic [NS-1:0]        ssink_d;

  localparam logic [LOW_CNT_W-1:0] SHUT_LIM = LOW_CNT_W'(SHUTDOWN_CYC);

  function automatic logic [CUR_W-1:0] next_level(input logic [CUR_W-1:0] cur,
                                                  input logic first);
    if (first || cur == CUR_ZERO) begin
      next_level = CUR_FULL_SCALE;
    end else begin
      next_level = cur - CUR_STEP;
    end
  endfunction

  always_comb begin
    ot_d       = {ot_q[1:0], over_temp};
    cool_d     = {cool_q[1:0], temp_cooled};
    ot_lvl_d   = (ot_q[1] == ot_q[2]) ? ot_q[2] : ot_lvl_q;
    cool_lvl_d = (cool_q[1] == cool_q[2]) ? cool_q[2] : cool_lvl_q;
    state_d    = state_q;
    cur_d      = cur_q;
    low_cnt_d  = low_cnt_q;
    therm_d    = therm_q;
    // Trip wins over cool-down so a flapping sensor cannot hold outputs on
    if (ot_lvl_q) begin
      therm_d = 1'b1;
    end else if (therm_q && cool_lvl_q) begin
      therm_d = 1'b0;
    end
    // Low-time counter saturates at the shutdown limit
    if (line_s.level) begin
      low_cnt_d = '0;
    end else if (low_cnt_q != SHUT_LIM) begin
      low_cnt_d = low_cnt_q + LOW_CNT_W'(1);
    end
    case (state_q)
      SWLD_OFF: begin
        cur_d = CUR_ZERO;
        // Rising line leaves shutdown, current stays zero
        if (line_s.rise) begin
          state_d = SWLD_ARMED;
        end
      end
      SWLD_ARMED: begin
        // Falling edges in the off state never get here
        if (line_s.fall) begin
          cur_d   = next_level(cur_q, 1'b1);
          state_d = SWLD_DIMMED;
        end
      end
      SWLD_DIMMED: begin
        if (line_s.fall) begin
          cur_d = next_level(cur_q, 1'b0);
        end
      end
      default: begin
        state_d = SWLD_OFF;
      end
    endcase
    // A low phase reaching the limit is shutdown, not a pulse
    if (state_q != SWLD_OFF && !line_s.level && low_cnt_q == SHUT_LIM) begin
      state_d = SWLD_OFF;
      cur_d   = CUR_ZERO;
    end
    for (int i = 0; i < NP; i++) begin
      psink_d[i] = (state_d != SWLD_OFF) && !therm_d && (cur_d != CUR_ZERO)
                   && !primary_sink_at_pump[i];
    end
    for (int j = 0; j < NS; j++) begin
      ssink_d[j] = (state_d != SWLD_OFF) && !therm_d && (cur_d != CUR_ZERO)
                   && !secondary_sink_at_pump[j];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ot_q       <= 3'h0;
      cool_q     <= 3'h0;
      ot_lvl_q   <= 1'b0;
      cool_lvl_q <= 1'b0;
      state_q    <= SWLD_OFF;
      cur_q      <= CUR_ZERO;
      low_cnt_q  <= '0;
      therm_q    <= 1'b0;
      psink_q    <= '0;
      ssink_q    <= '0;
    end else begin
      ot_q       <= ot_d;
      cool_q     <= cool_d;
      ot_lvl_q   <= ot_lvl_d;
      cool_lvl_q <= cool_lvl_d;
      state_q    <= state_d;
      cur_q      <= cur_d;
      low_cnt_q  <= low_cnt_d;
      therm_q    <= therm_d;
      psink_q    <= psink_d;
      ssink_q    <= ssink_d;
    end
  end

  // Thermal cut gates the sinks, the code is kept for resume
  assign device_enabled      = (state_q != SWLD_OFF);
  assign thermal_shutdown    = therm_q;
  assign current_code        = (therm_q || state_q == SWLD_OFF) ? CUR_ZERO : cur_q;
  assign primary_led_sinks   = psink_q;
  assign secondary_led_sinks = ssink_q;
endmodule

// >>> src/swld_line_sync.sv
// Three-flop synchroniser for the common control line with edge strobes.
// Assumes the line is asynchronous to core_clk.
`timescale 1ns/10ps
module swld_line_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic line_in,
  swld_sync_if.src  sync
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    stage_d = {stage_q[1:0], line_in};
    level_d = level_q;
    // Stage 0 is metastable; only stages 1 and 2 are compared
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign sync.level = level_q;
  assign sync.fall  = level_q & ~level_d;
  assign sync.rise  = ~level_q & level_d;
endmodule

// >>> src/swld_pkg.sv
// Package for the single-wire LED dimming block: timing, current code, channel counts.
// Assumes a 200 MHz core clock; the cycle counts derive from CLK_MHZ.
package swld_pkg;
  localparam int unsigned CLK_PERIOD_PS      = 5000;
  localparam int unsigned CLK_MHZ            = 200;
  // Longest low time that still counts as a dimming pulse, in us
  localparam int unsigned PULSE_LOW_MAX_US   = 500;
  // Low time after which the device shuts down, in us
  localparam int unsigned SHUTDOWN_LOW_US    = 1500;
  // Both counts are the time in us times CLK_MHZ, an exact product with no rounding
  localparam int unsigned PULSE_LOW_MAX_CYC  = PULSE_LOW_MAX_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_LOW_CYC   = SHUTDOWN_LOW_US * CLK_MHZ;
  localparam int unsigned LOW_CNT_W          = 20;
  // Current code in 1 mA steps
  localparam int unsigned CUR_W              = 5;
  localparam logic [4:0]  CUR_FULL_SCALE     = 5'h1f;
  localparam logic [4:0]  CUR_STEP           = 5'h01;
  localparam logic [4:0]  CUR_ZERO           = 5'h00;
  localparam int unsigned PRIMARY_SINKS      = 4;
  localparam int unsigned SECONDARY_SINKS    = 2;
  typedef enum logic [1:0] {
    SWLD_OFF    = 2'b00,
    SWLD_ARMED  = 2'b01,
    SWLD_DIMMED = 2'b11
  } swld_state_e;
endpackage

// >>> src/swld_sync_if.sv
// Interface carrying a synchronised line level and its edge strobes.
// Driven by the synchroniser, read by the dimming controller.
`timescale 1ns/10ps
interface swld_sync_if;
  logic level;
  logic fall;
  logic rise;
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface

// >>> verification/swld_ctrl_asserts.sv
// Port checker for the dimming controller.
// Bound into swld_ctrl; sync latency assumed under 8 cycles.
`timescale 1ns/10ps
module swld_ctrl_asserts #(
  parameter int unsigned SHUTDOWN_CYC = 200,
  parameter int unsigned NP = 4,
  parameter int unsigned NS = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic common_line,
  input wire logic over_temp,
  input wire logic temp_cooled,
  input wire logic [NP-1:0] primary_sink_at_pump,
  input wire logic [NS-1:0] secondary_sink_at_pump,
  input wire logic device_enabled,
  input wire logic thermal_shutdown,
  input wire logic [4:0] current_code,
  input wire logic [NP-1:0] primary_led_sinks,
  input wire logic [NS-1:0] secondary_led_sinks
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int unsigned low_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) low_n <= 0;
    else low_n <= common_line ? 0 : low_n + 1;
  end
  sequence s_hot; over_temp[*8]; endsequence
  sequence s_warm; (!temp_cooled)[*5]; endsequence
  a_off_code_zero: assert property (!device_enabled |-> current_code == 5'h00)
    else $error("code set while off");
  a_enable_at_zero: assert property ($rose(device_enabled) |-> current_code == 5'h00)
    else $error("code not zero on enable");
  a_code_steps: assert property ($changed(current_code) && device_enabled
    && $past(device_enabled) && !thermal_shutdown && !$past(thermal_shutdown)
    |-> current_code == 5'($past(current_code) - 5'h01)) else $error("bad code step");
  a_long_low_off: assert property (low_n == SHUTDOWN_CYC + 8 |-> !device_enabled)
    else $error("no shutdown on long low");
  a_pump_sink_off: assert property (((primary_led_sinks & $past(primary_sink_at_pump))
    | (secondary_led_sinks & $past(secondary_sink_at_pump))) == '0) else $error("pump sink on");
  a_hot_cuts: assert property (s_hot |-> thermal_shutdown)
    else $error("no thermal cut");
  a_hot_dark: assert property (thermal_shutdown[*2] |-> current_code == 5'h00
    && primary_led_sinks == '0 && secondary_led_sinks == '0) else $error("lit while hot");
  a_cool_wait: assert property (s_warm ##0 thermal_shutdown |=> thermal_shutdown)
    else $error("early thermal exit");
endmodule
bind swld_ctrl swld_ctrl_asserts #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .NP(NP), .NS(NS)) i_asserts (
  .core_clk, .rst_n, .common_line, .over_temp, .temp_cooled, .primary_sink_at_pump,
  .secondary_sink_at_pump, .device_enabled, .thermal_shutdown, .current_code,
  .primary_led_sinks, .secondary_led_sinks);

// >>> verification/swld_ctrl_tb.sv
// Bench for the dimming controller with a short shutdown count.
// Host model drives the line; checker comes in by bind.
`timescale 1ns/10ps
module swld_ctrl_tb;
  import swld_pkg::*;
  typedef struct {int n; logic [4:0] code;} swld_row_s;
  swld_row_s rows [5] = '{'{1, 5'h1f}, '{2, 5'h1e}, '{31, 5'h01}, '{32, 5'h00}, '{33, 5'h1f}};
  logic core_clk, rst_n, line, busy, over_temp, temp_cooled, en, hot;
  logic [1:0] cmd, pump_s, sec;
  logic [3:0] pump_p, pri;
  logic [4:0] code;
  int n_mismatch = 0, compares = 0, cyc = 0;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  swld_host i_swld_host (.core_clk, .cmd, .line, .busy);
  swld_ctrl #(.SHUTDOWN_CYC(200)) i_swld_ctrl (.core_clk, .rst_n, .common_line(line),
    .over_temp, .temp_cooled, .primary_sink_at_pump(pump_p), .secondary_sink_at_pump(pump_s),
    .device_enabled(en), .thermal_shutdown(hot), .current_code(code),
    .primary_led_sinks(pri), .secondary_led_sinks(sec));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic host(input logic [1:0] c);
    @(posedge core_clk) cmd <= c;
    @(posedge core_clk) cmd <= 2'h0;
    @(posedge core_clk);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Run is about 12000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    over_temp = 1'b0;
    temp_cooled = 1'b1;
    pump_p = 4'h0;
    pump_s = 2'h0;
    cmd = 2'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(code, 8'h00);
    foreach (rows[i]) begin
      host(2'h2);
      chk(en, 8'h00);
      host(2'h3);
      chk(en, 8'h01);
      chk(code, 8'h00);
      repeat (rows[i].n) host(2'h1);
      chk(code, rows[i].code);
      chk(pri, {4{|rows[i].code}});
    end
    pump_p <= 4'h5;
    pump_s <= 2'h2;
    repeat (4) @(posedge core_clk);
    chk(pri, 8'h0a);
    chk(sec, 8'h01);
    over_temp <= 1'b1;
    temp_cooled <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(hot, 8'h01);
    chk(pri, 8'h00);
    over_temp <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(hot, 8'h01);
    temp_cooled <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(hot, 8'h00);
    chk(code, 8'h1f);
    // Mid-run reset with the line left high: outputs clear, then re-enable at zero
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(en, 8'h00);
    chk(code, 8'h00);
    chk(pri, 8'h00);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(en, 8'h01);
    chk(code, 8'h00);
    chk(sec, 8'h00);
    summarize();
  end
endmodule

// >>> verification/swld_host.sv
// Host pin model driving the shared enable and dimming line.
// Bench commands: 1 dimming pulse, 2 long low, 3 raise line.
`timescale 1ns/10ps
module swld_host #(
  parameter int LOW_CYC  = 20,
  parameter int HIGH_CYC = 80,
  parameter int OFF_CYC  = 260
) (
  input  wire logic       core_clk,
  input  wire logic [1:0] cmd,
  output logic            line,
  output logic            busy
);
  initial begin
    line = 1'b0;
    busy = 1'b0;
  end
  always begin
    @(posedge core_clk);
    if (cmd != 2'h0) begin
      busy <= 1'b1;
      line <= (cmd == 2'h3);
      case (cmd)
        2'h1: begin
          repeat (LOW_CYC) @(posedge core_clk);
          line <= 1'b1;
          repeat (HIGH_CYC) @(posedge core_clk);
        end
        2'h2: repeat (OFF_CYC) @(posedge core_clk);
        default: repeat (LOW_CYC) @(posedge core_clk);
      endcase
      busy <= 1'b0;
    end
  end
endmodule
